/* hdl/dprc_pkg.sv */
// Constants for the host-side port controller of an asynchronous dual-port RAM.
// Assumes a 250 MHz core clock; all pin timing is counted in core_clk cycles.
package dprc_pkg;
    // Core clock period in picoseconds
    localparam int CLK_PERIOD_PS = 4000;
    // Pin timing figures, nanoseconds, fastest grade
    localparam int WRITE_PULSE_NS = 12;           // Least strobe low time
    localparam int HIGHZ_NS = 10;                 // Outputs turn off after strobe
    localparam int DATA_SETUP_NS = 10;            // Data valid to end of write
    localparam int WRITE_HOLD_NS = 12;            // Strobe low after busy releases
    localparam int ACCESS_NS = 15;                // Read and busy access time
    localparam int WRITE_TO_DATA_NS = 30;         // Port to port delay
    localparam int SEM_WRITE_TO_READ_NS = 5;      // Flag write to read gap
    // Least times round up to whole cycles
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OE_LOW_PULSE_CYC = ((HIGHZ_NS + DATA_SETUP_NS) * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int WRITE_HOLD_CYC = (WRITE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEM_GAP_CYC = (SEM_WRITE_TO_READ_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int PORT_DELAY_CYC = (WRITE_TO_DATA_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // Width of the timing counter
    localparam int CNT_W = 4;
    // Data width and address width of one port
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    // Request kinds on the user side
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_SEM_READ = 2'h2;
    localparam logic [1:0] OP_SEM_WRITE = 2'h3;
endpackage : dprc_pkg

/* hdl/dprc_cycle_timer.sv */
// Down counter that times one phase of a pin cycle.
// Assumes a load pulse carries the phase length; done is high while the count is zero.
module dprc_cycle_timer #(
    parameter int W = dprc_pkg::CNT_W
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [W-1:0] load_value,
    output logic done
);
    // Timer state held as one packed struct
    typedef struct packed {
        logic [W-1:0] count;
    } dprc_tmr_t;
    dprc_tmr_t state_reg;
    dprc_tmr_t state_next;

    // Load wins over counting down
    always_comb begin
        state_next = state_reg;
        if (load) begin
            state_next.count = load_value;
        end else if (state_reg.count != '0) begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    // Synchronous reset to an idle timer
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign done = (state_reg.count == '0);
endmodule : dprc_cycle_timer

/* hdl/dprc_host_port.sv */
// Notes on behaviour
// RULE1 - Enable low flag high selects memory array
// RULE2 - Address changes only with strobe high
// RULE3 - Device writes while enable and strobe low
// RULE4 - Late enable fall keeps device outputs off
// RULE5 - Strobe long enough when output drive low
// RULE6 - No data driven while device drives pins
// RULE7 - Flag read returns value on all lines
// RULE8 - Contended flag goes to exactly one side
// RULE9 - Primary grants earlier stable port first
// RULE10 - Secondary device ignores arbitration set-up
// RULE11 - Busy asserted within access time
// RULE12 - Busy released within delay after mismatch
// RULE13 - Busy follows enable within bounded delay
// RULE14 - Secondary busy input low before write
// RULE15 - Strobe held low after busy returns high
// RULE16 - Written data visible at other port later
// RULE17 - Release to data delay is computed bound
// RULE18 - Low busy blocks the port's writes
// RULE19 - Both busy outputs never low together
//
// Host controller driving one port of an asynchronous dual-port RAM.
// Assumes pins are synchronous to core_clk and the data bus is resolved outside.
module dprc_host_port #(
    parameter int ADDR_W = dprc_pkg::ADDR_W,
    parameter int DATA_W = dprc_pkg::DATA_W
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic [1:0] req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_sem_bad,
    output logic [ADDR_W-1:0] ram_addr,
    output logic ram_port_en_n,
    output logic flag_select_n,
    output logic ram_write_n,
    output logic ram_out_drive_n,
    output logic [DATA_W-1:0] ram_data_out,
    output logic ram_data_oe,
    input wire logic [DATA_W-1:0] ram_data_in,
    input wire logic ram_busy_n
);
    // Controller phases
    typedef enum {
        DPRC_IDLE,
        DPRC_SETUP,
        DPRC_WRITE,
        DPRC_HOLD,
        DPRC_READ,
        DPRC_GAP
    } dprc_phase_t;

    // All controller state in one packed struct
    typedef struct packed {
        dprc_phase_t phase;
        logic [1:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic port_en_n;
        logic flag_n;
        logic write_n;
        logic out_drive_n;
        logic data_oe;
        logic ready;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic sem_bad;
        logic busy_seen;
    } dprc_state_t;

    dprc_state_t state_reg;
    dprc_state_t state_next;
    logic tmr_load;                              // Start a timed phase
    logic [dprc_pkg::CNT_W-1:0] tmr_value;       // Length of that phase
    logic tmr_done;                              // Phase has run out

    // True for the two semaphore request kinds
    function automatic logic dprc_is_sem(input logic [1:0] op);
        return (op == dprc_pkg::OP_SEM_READ) || (op == dprc_pkg::OP_SEM_WRITE);
    endfunction : dprc_is_sem

    // True for the two write request kinds
    function automatic logic dprc_is_write(input logic [1:0] op);
        return (op == dprc_pkg::OP_WRITE) || (op == dprc_pkg::OP_SEM_WRITE);
    endfunction : dprc_is_write

    // Flag read is good only when every line agrees
    function automatic logic dprc_all_same(input logic [DATA_W-1:0] d);
        return (d == '0) || (d == '1);
    endfunction : dprc_all_same

    dprc_cycle_timer #(
        .W(dprc_pkg::CNT_W)
    ) u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(tmr_load),
        .load_value(tmr_value),
        .done(tmr_done)
    );

    // Next-state logic for the pin sequence
    always_comb begin
        state_next = state_reg;
        state_next.rsp_valid = 1'b0;
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state_reg.phase)
            DPRC_IDLE: begin
                // Address only moves while strobe and enable are high; see RULE2
                if (req_valid && state_reg.ready) begin
                    state_next.op = req_op;
                    state_next.addr = req_addr;
                    state_next.wdata = req_wdata;
                    state_next.ready = 1'b0;
                    state_next.busy_seen = 1'b0;
                    state_next.phase = DPRC_SETUP;
                end
            end
            DPRC_SETUP: begin
                // Select array or flags, held through the cycle; see RULE1
                state_next.port_en_n = dprc_is_sem(state_reg.op);
                state_next.flag_n = !dprc_is_sem(state_reg.op);
                // Output drive high on writes, so the short pulse suffices; see RULE5
                state_next.out_drive_n = dprc_is_write(state_reg.op);
                if (dprc_is_write(state_reg.op)) begin
                    // Strobe falls with the select, so device outputs stay off; see RULE4
                    state_next.write_n = 1'b0;
                    // Device outputs never drove, so data may go out now; see RULE6
                    state_next.data_oe = 1'b1;
                    state_next.phase = DPRC_WRITE;
                    tmr_load = 1'b1;
                    tmr_value = dprc_pkg::CNT_W'(dprc_pkg::WRITE_PULSE_CYC);
                end else begin
                    state_next.phase = DPRC_READ;
                    tmr_load = 1'b1;
                    tmr_value = dprc_pkg::CNT_W'(dprc_pkg::ACCESS_CYC);
                end
            end
            DPRC_WRITE: begin
                // Busy low defers the write; see RULE18
                // Arbiter timing is the device's; busy is obeyed as seen; see RULE9 RULE10 RULE11
                // Only this port's busy is watched, never both sides; see RULE12 RULE13 RULE19
                if (!ram_busy_n) begin
                    state_next.busy_seen = 1'b1;
                    tmr_load = 1'b1;
                    tmr_value = dprc_pkg::CNT_W'(dprc_pkg::WRITE_HOLD_CYC);
                end else if (tmr_done) begin
                    // Array or flag written while its select and strobe were low; see RULE3
                    state_next.write_n = 1'b1;
                    state_next.phase = DPRC_HOLD;
                end
                // Hold time after busy rises is reloaded above; see RULE15
            end
            DPRC_HOLD: begin
                // Release selects one cycle after the strobe rises
                state_next.port_en_n = 1'b1;
                state_next.flag_n = 1'b1;
                state_next.data_oe = 1'b0;
                state_next.phase = DPRC_GAP;
                tmr_load = 1'b1;
                // Later reads see data after the port delay; see RULE16
                // Flag writes are read back after the gap to learn the winner; see RULE8
                // Gap also covers the release-to-data delay after busy; see RULE17
                tmr_value = dprc_is_sem(state_reg.op)
                    ? dprc_pkg::CNT_W'(dprc_pkg::SEM_GAP_CYC)
                    : dprc_pkg::CNT_W'(dprc_pkg::PORT_DELAY_CYC);
                state_next.rsp_valid = 1'b1;
                state_next.sem_bad = 1'b0;
            end
            DPRC_READ: begin
                if (tmr_done) begin
                    state_next.rdata = ram_data_in;
                    // Flag value must show on every data line; see RULE7
                    state_next.sem_bad = dprc_is_sem(state_reg.op) && !dprc_all_same(ram_data_in);
                    state_next.rsp_valid = 1'b1;
                    state_next.port_en_n = 1'b1;
                    state_next.flag_n = 1'b1;
                    state_next.out_drive_n = 1'b1;
                    state_next.phase = DPRC_GAP;
                    tmr_load = 1'b1;
                    tmr_value = dprc_pkg::CNT_W'(1);
                end
            end
            DPRC_GAP: begin
                if (tmr_done) begin
                    state_next.ready = 1'b1;
                    state_next.phase = DPRC_IDLE;
                end
            end
            default: begin
                state_next.phase = DPRC_IDLE;
            end
        endcase
    end

    // Synchronous reset leaves every pin inactive
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= '{phase: DPRC_IDLE, op: 2'h0, addr: '0, wdata: '0,
                port_en_n: 1'b1, flag_n: 1'b1, write_n: 1'b1, out_drive_n: 1'b1,
                data_oe: 1'b0, ready: 1'b1, rsp_valid: 1'b0, rdata: '0,
                sem_bad: 1'b0, busy_seen: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_ready = state_reg.ready;
    assign rsp_valid = state_reg.rsp_valid;
    assign rsp_rdata = state_reg.rdata;
    assign rsp_sem_bad = state_reg.sem_bad;
    assign ram_addr = state_reg.addr;
    assign ram_port_en_n = state_reg.port_en_n;
    assign flag_select_n = state_reg.flag_n;
    assign ram_write_n = state_reg.write_n;
    assign ram_out_drive_n = state_reg.out_drive_n;
    assign ram_data_out = state_reg.wdata;
    assign ram_data_oe = state_reg.data_oe;

    // Address steady while strobe and enable are both low
    a_addr_stable: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE2
        (!ram_write_n && !ram_port_en_n) |=> $stable(ram_addr))
        else $error("address moved during write");

    // Never both selects low at once
    a_select_excl: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE1
        !(!ram_port_en_n && !flag_select_n))
        else $error("array and flag selected together");

    // Strobe low only with a select low
    a_strobe_sel: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE3
        !ram_write_n |-> (!ram_port_en_n || !flag_select_n))
        else $error("strobe low without select");

    // Data driven only with output drive high
    a_no_fight: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE6
        ram_data_oe |-> ram_out_drive_n)
        else $error("data driven while device may drive");

    // Strobe pulse at least the minimum width
    a_pulse_width: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE5
        $fell(ram_write_n) |-> !ram_write_n [*3])
        else $error("write pulse too short");

    // Strobe stays low for the hold after busy rises
    a_busy_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE15
        (!ram_write_n && $rose(ram_busy_n)) |-> !ram_write_n [*3])
        else $error("write hold after busy violated");

    // Strobe held and contention noted while busy stays low
    a_busy_defer: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE18
        (!ram_write_n && !ram_busy_n) |=> (!ram_write_n && state_reg.busy_seen))
        else $error("write released during contention");
endmodule : dprc_host_port

/* dv/dprc_dev_model.sv */
// Behavioural model of one port of the dual-port RAM: array, flags and contention pin.
// Assumes host pins change on rising core_clk edges; the model samples them on falling edges.
module dprc_dev_model (
    input wire logic core_clk,
    input wire logic [15:0] ram_addr,
    input wire logic ram_port_en_n,
    input wire logic flag_select_n,
    input wire logic ram_write_n,
    input wire logic ram_out_drive_n,
    input wire logic [7:0] ram_data_out,
    input wire logic ram_data_oe,
    input wire logic busy_req,
    input wire logic sem_skew,
    output logic [7:0] ram_data_in,
    output logic ram_busy_n,
    output logic dev_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535]; // Shared cells
    logic [7:0] sem_flag = 8'hff; // One bit per flag, all free
    logic [7:0] wr_data_reg; // Data seen while strobe low
    logic [7:0] last_reg = 8'h00; // Last resolved pin value
    logic write_n_prev = 1'h1;
    logic array_sel;
    logic sem_sel;
    logic [7:0] dev_data;
    // Select decode, never both at once
    assign array_sel = !ram_port_en_n && flag_select_n;
    assign sem_sel = ram_port_en_n && !flag_select_n;
    // Other side winning is commanded by the bench; only this side ever goes low
    assign ram_busy_n = !busy_req;
    // Drive only outside a write, so a late select keeps outputs off
    assign dev_drive = ram_write_n && !ram_out_drive_n && (array_sel || sem_sel);
    // Flag read replicates the value; skew breaks one line on command
    assign dev_data = array_sel ? mem[ram_addr]
        : {8{sem_flag[ram_addr[2:0]]}} ^ {7'h00, sem_skew};
    // Released lines show the inverse of the last value, never a held copy
    assign ram_data_in = ram_data_oe ? ram_data_out : (dev_drive ? dev_data : ~last_reg);
    // Write lands at strobe release, only while selected and not contended
    always @(negedge core_clk) begin
        last_reg <= ram_data_in;
        write_n_prev <= ram_write_n;
        if (!ram_write_n) begin
            wr_data_reg <= ram_data_out;
        end
        if (!write_n_prev && ram_write_n && ram_busy_n) begin
            if (array_sel) begin
                mem[ram_addr] <= wr_data_reg;
            end
            if (sem_sel) begin
                sem_flag[ram_addr[2:0]] <= wr_data_reg[0];
            end
        end
    end
endmodule : dprc_dev_model

/* dv/dual_port_ram_arbitration_tb_top.sv */
// Self-checking bench: host port controller against the device model.
// Assumes one 250 MHz clock; bench inputs change 1 ns after each rising edge.
module dual_port_ram_arbitration_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0] op;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
        int lat;
        logic skew;
    } dprc_row_t;
    logic core_clk = 1'h0, reset_n = 1'h0, req_valid = 1'h0, busy_req = 1'h0, skew = 1'h0;
    logic [1:0] req_op = 2'h0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, rsp_sem_bad, ram_port_en_n, flag_select_n, ram_write_n;
    logic ram_out_drive_n, ram_data_oe, ram_busy_n, dev_drive;
    logic [15:0] ram_addr, addr_prev;
    logic [7:0] rsp_rdata, ram_data_out, ram_data_in;
    logic wn_prev = 1'h1, en_prev = 1'h1;
    logic [3:0] since_busy = 4'hf, wlow = 4'h0; // Saturating monitors
    int err_total = 0, compares = 0, cycles = 0, lat;
    dprc_row_t rows [9];
    dprc_host_port uut (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_sem_bad(rsp_sem_bad),
        .ram_addr(ram_addr), .ram_port_en_n(ram_port_en_n), .flag_select_n(flag_select_n),
        .ram_write_n(ram_write_n), .ram_out_drive_n(ram_out_drive_n),
        .ram_data_out(ram_data_out), .ram_data_oe(ram_data_oe), .ram_data_in(ram_data_in),
        .ram_busy_n(ram_busy_n));
    dprc_dev_model dev (.core_clk(core_clk), .ram_addr(ram_addr), .ram_port_en_n(ram_port_en_n),
        .flag_select_n(flag_select_n), .ram_write_n(ram_write_n),
        .ram_out_drive_n(ram_out_drive_n), .ram_data_out(ram_data_out),
        .ram_data_oe(ram_data_oe), .busy_req(busy_req), .sem_skew(skew),
        .ram_data_in(ram_data_in), .ram_busy_n(ram_busy_n), .dev_drive(dev_drive));
    // Clock, 4 ns period
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // One comparison, four-state
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Single exit of the run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    // Idle pin state: selects, strobe, drive high; oe low; ready high; no response
    task automatic chk_idle();
        chk("idle_pins", 16'h007a, {9'h000, ram_port_en_n, flag_select_n, ram_write_n,
            ram_out_drive_n, ram_data_oe, req_ready, rsp_valid});
    endtask : chk_idle
    // One request; lat counts edges from take to response, bounded
    task automatic do_req(input logic [1:0] op, input logic [15:0] addr,
        input logic [7:0] wdata, output int lat);
        int n;
        n = 0;
        while (req_ready !== 1'h1 && n < 50) begin
            @(posedge core_clk);
            #1 n++;
        end
        req_valid = 1'h1;
        req_op = op;
        req_addr = addr;
        req_wdata = wdata;
        @(posedge core_clk);
        #1 req_valid = 1'h0;
        lat = 0;
        while (rsp_valid !== 1'h1 && lat < 60) begin
            @(posedge core_clk);
            #1 lat++;
        end
        chk("rsp_valid", 16'h0001, 16'(rsp_valid));
    endtask : do_req
    // Pin monitor on falling edges, where registered pins are settled
    always @(negedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish();
        end
        if (reset_n) begin
            chk("both_selects", 16'h0000, 16'(!ram_port_en_n && !flag_select_n));
            chk("addr_move", 16'h0000, 16'(ram_addr !== addr_prev && !ram_write_n
                && !wn_prev && !ram_port_en_n && !en_prev));
            chk("bus_fight", 16'h0000, 16'(ram_data_oe && dev_drive));
            if (ram_write_n && !wn_prev) begin
                chk("write_hold", 16'h0000, 16'(since_busy < 4'h3));
                chk("strobe_len", 16'h0001, 16'(wlow >= (ram_out_drive_n
                    ? dprc_pkg::WRITE_PULSE_CYC : dprc_pkg::OE_LOW_PULSE_CYC)));
            end
        end
        addr_prev <= ram_addr;
        wn_prev <= ram_write_n;
        en_prev <= ram_port_en_n;
        wlow <= ram_write_n ? 4'h0 : wlow + (wlow != 4'hf);
        since_busy <= !ram_busy_n ? 4'h0 : since_busy + (since_busy != 4'hf);
    end
    // Main sequence: reset, table, then contention and mid-run reset
    initial begin
        rows = '{'{dprc_pkg::OP_WRITE, 16'hffff, 8'ha5, 8'h00, 6, 1'h0},
            '{dprc_pkg::OP_WRITE, 16'h0000, 8'h3c, 8'h00, 6, 1'h0},
            '{dprc_pkg::OP_READ, 16'hffff, 8'h00, 8'ha5, 6, 1'h0},
            '{dprc_pkg::OP_READ, 16'h0000, 8'h00, 8'h3c, 6, 1'h0},
            '{dprc_pkg::OP_SEM_WRITE, 16'h0003, 8'h00, 8'h00, 0, 1'h0},
            '{dprc_pkg::OP_SEM_READ, 16'h0003, 8'h00, 8'h00, 0, 1'h0},
            '{dprc_pkg::OP_SEM_WRITE, 16'h0003, 8'h01, 8'h00, 0, 1'h0},
            '{dprc_pkg::OP_SEM_READ, 16'h0003, 8'h00, 8'hff, 0, 1'h0},
            '{dprc_pkg::OP_SEM_READ, 16'h0003, 8'h00, 8'hff, 0, 1'h1}};
        repeat (16) @(posedge core_clk);
        #1 reset_n = 1'h1;
        chk_idle();
        foreach (rows[i]) begin
            skew = rows[i].skew;
            do_req(rows[i].op, rows[i].addr, rows[i].wdata, lat);
            if (rows[i].lat != 0) begin
                chk("latency", 16'(rows[i].lat), 16'(lat));
            end
            if (rows[i].op[0] == 1'h0 && !rows[i].skew) begin
                chk("rdata", {8'h00, rows[i].exp}, {8'h00, rsp_rdata});
            end
            if (rows[i].op == dprc_pkg::OP_SEM_READ) begin
                chk("sem_bad", 16'(rows[i].skew), 16'(rsp_sem_bad));
            end
        end
        skew = 1'h0;
        // Contention during a write: strobe held until busy releases, then data lands
        fork
            do_req(dprc_pkg::OP_WRITE, 16'h4242, 8'h81, lat);
            begin
                wait (req_valid === 1'h1);
                // Busy goes low before the strobe falls, as a secondary port needs
                repeat (1) @(posedge core_clk);
                #1 busy_req = 1'h1;
                repeat (6) @(posedge core_clk);
                #1 busy_req = 1'h0;
            end
        join
        // Six busy edges, a three-cycle hold, strobe release, then response
        chk("busy_stretch", 16'h000b, 16'(lat));
        do_req(dprc_pkg::OP_READ, 16'h4242, 8'h00, lat);
        chk("busy_rdata", 16'h0081, {8'h00, rsp_rdata});
        // Reset in the middle of a write returns every pin to idle
        do_req(dprc_pkg::OP_WRITE, 16'h0100, 8'h11, lat);
        fork
            do_req(dprc_pkg::OP_WRITE, 16'h0200, 8'h22, lat);
            begin
                wait (req_valid === 1'h1);
                repeat (3) @(posedge core_clk);
                #1 reset_n = 1'h0;
                repeat (2) @(posedge core_clk);
                #1 chk_idle();
                reset_n = 1'h1;
            end
        join_any
        disable fork;
        repeat (2) @(posedge core_clk);
        #1 chk_idle();
        tally_and_finish();
    end
endmodule : dual_port_ram_arbitration_tb_top
